// [design/mrid_alu.sv]
// arithmetic and logic unit for byte, bit and literal operations
`timescale 1ns/100ps
module mrid_alu (
   mrid_exec_if.alu ex
);
   wire [8:0] add_w  = {1'b0, ex.opa} + {1'b0, ex.opb};
   wire [8:0] sub_w  = {1'b0, ex.opa} + {1'b0, ~ex.opb} + 9'h001;
   wire [4:0] add_lo = {1'b0, ex.opa[3:0]} + {1'b0, ex.opb[3:0]};
   wire [4:0] sub_lo = {1'b0, ex.opa[3:0]} + {1'b0, ~ex.opb[3:0]} + 5'h01;
   wire [7:0] mask   = 8'h01 << ex.bsel;

   always_comb begin
      ex.res   = ex.opa;
      ex.cout  = ex.cin;
      ex.dcout = 1'b0;
      unique case (ex.op)
         mrid_pkg::ALU_ADD: begin
            ex.res   = add_w[7:0];
            ex.cout  = add_w[8];
            ex.dcout = add_lo[4];
         end
         mrid_pkg::ALU_SUB: begin
            // carry and digit carry read as not-borrow
            ex.res   = sub_w[7:0];
            ex.cout  = sub_w[8];
            ex.dcout = sub_lo[4];
         end
         mrid_pkg::ALU_AND:  ex.res = ex.opa & ex.opb;
         mrid_pkg::ALU_OR:   ex.res = ex.opa | ex.opb;
         mrid_pkg::ALU_XOR:  ex.res = ex.opa ^ ex.opb;
         mrid_pkg::ALU_CLR:  ex.res = 8'h00;
         mrid_pkg::ALU_COM:  ex.res = ~ex.opa;
         mrid_pkg::ALU_DEC:  ex.res = ex.opa - 8'h01;
         mrid_pkg::ALU_INC:  ex.res = ex.opa + 8'h01;
         mrid_pkg::ALU_RLC: begin
            ex.res  = {ex.opa[6:0], ex.cin};
            ex.cout = ex.opa[7];
         end
         mrid_pkg::ALU_RRC: begin
            ex.res  = {ex.cin, ex.opa[7:1]};
            ex.cout = ex.opa[0];
         end
         mrid_pkg::ALU_SWAP: ex.res = {ex.opa[3:0], ex.opa[7:4]};
         mrid_pkg::ALU_BCLR: ex.res = ex.opa & ~mask;
         mrid_pkg::ALU_BSET: ex.res = ex.opa | mask;
         default:            ex.res = ex.opa;
      endcase
   end

   assign ex.zout = (ex.res == 8'h00);
endmodule

// [design/mrid_cfg.svh]
// offsets, bit positions, reset values and timing counts of the decoder
`ifndef MRID_CFG_SVH
`define MRID_CFG_SVH
`define MRID_OSC_PER_CYC 4
`define MRID_A_CTRL      5'h00
`define MRID_A_STAT      5'h04
`define MRID_A_PC        5'h08
`define MRID_A_ACC       5'h0c
`define MRID_A_INSN      5'h10
`define MRID_CTRL_RUN    0
`define MRID_CTRL_PSA    1
`define MRID_CTRL_WAKE   2
`define MRID_F_TIMER_ZERO_COUNT      7'h01
`define MRID_F_STAT      7'h03
`define MRID_F_PORT      7'h06
`define MRID_F_PC_HIGH_LATCH    7'h0a
`define MRID_SB_C        0
`define MRID_SB_DC       1
`define MRID_SB_Z        2
`define MRID_RST_PC      13'h0000
`define MRID_RESP_OK     2'h0
`define MRID_RESP_ERR    2'h2
`endif

// [design/mrid_core.sv]
// instruction decoder top: fetch, decode, execute and register slave
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`include "mrid_cfg.svh"
// Overview of operation
// - d=0 result to accumulator, d=1 to file
// - add and subtract file update C, DC, Z
// - and, or, xor with file update Z only
// - clear file or accumulator, setting Z
// - rotate through carry changes only C
// - decrement/increment skip on zero, no flags
// - bit clear and bit set, no flags
// - bit tests skip on clear or set
// - branch or true test adds a no-op cycle
// - add literal into accumulator, updating C, DC, Z
// - literal minus accumulator, updating C, DC, Z
// - literal logic ops set Z; load literal none
// - call pushes return, jump loads same target
// - returns pop stack in two cycles
// - standby and watchdog clear update TO, PD
// - read-modify-write of port reads pin levels
// - writing timer zero clears assigned prescaler
// - 7-bit field addresses all 128 files
// - instruction cycle spans four clocks
module mrid_core #(
   parameter int STACK_DEPTH = 8
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [4:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output wire logic        s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output wire logic        s_axi_wready,
   output wire logic [1:0]  s_axi_bresp,
   output wire logic        s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [4:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output wire logic        s_axi_arready,
   output wire logic [31:0] s_axi_rdata,
   output wire logic [1:0]  s_axi_rresp,
   output wire logic        s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output wire logic [12:0] prog_addr,
   input  wire logic [13:0] prog_word,
   input  wire logic [7:0]  pins_in,
   output wire logic [7:0]  port_out,
   output wire logic        prescaler_clear,
   output wire logic        watchdog_clear,
   output wire logic        standby
);
   localparam int SPW = $clog2(STACK_DEPTH);

   mrid_exec_if ex ();

   mrid_alu u_alu (
      .ex (ex)
   );

   mrid_file #(
      .DEPTH (128)
   ) u_file (
      .aclk    (aclk),
      .pins_in (pins_in),
      .ex      (ex)
   );

   mrid_pkg::mrid_state_t  state_reg;
   mrid_pkg::mrid_state_t  state_next;
   mrid_pkg::mrid_alu_op_t alu_op;
   logic [1:0]             phase_reg;
   logic [12:0]            pc_reg;
   logic [7:0]             acc_reg;
   logic [4:0]             pc_high_latch_reg;
   logic                   c_reg;
   logic                   dc_reg;
   logic                   z_reg;
   logic                   pd_reg;
   logic                   to_reg;
   logic [SPW-1:0]         sp_reg;
   logic [12:0]            stack_reg [STACK_DEPTH];
   logic [13:0]            insn_reg;
   logic                   run_reg;
   logic                   psa_reg;
   logic [7:0]             port_out_reg;
   logic                   prescaler_clear_reg;
   logic                   watchdog_clear_reg;
   logic                   standby_reg;

   // instruction fields
   wire [13:0] iw   = prog_word;
   wire [3:0]  bop  = iw[11:8];
   wire        dsel = iw[7];
   wire [6:0]  fa   = iw[6:0];
   wire [7:0]  lit  = iw[7:0];

   // class decode
   wire is_byte   = (iw[13:12] == 2'h0);
   wire is_bit    = (iw[13:12] == 2'h1);
   wire is_jmp    = (iw[13:12] == 2'h2);
   wire is_lit    = (iw[13:12] == 2'h3);
   wire is_misc   = is_byte && bop == 4'h0 && !dsel;
   wire is_store  = is_byte && bop == 4'h0 && dsel;
   wire is_ret    = is_misc && fa == 7'h08;
   wire is_interrupt_return = is_misc && fa == 7'h09;
   wire is_sleep  = is_misc && fa == 7'h63;
   wire is_wdt    = is_misc && fa == 7'h64;
   wire is_call   = is_jmp && !iw[11];
   wire is_jump_absolute   = is_jmp && iw[11];
   wire is_load_literal  = is_lit && bop[3:2] == 2'h0;
   wire is_return_with_literal  = is_lit && bop[3:2] == 2'h1;
   wire is_add_literal  = is_lit && bop[3:1] == 3'h7;
   wire is_sub_acc_from_literal  = is_lit && bop[3:1] == 3'h6;
   wire is_llog   = is_lit && (bop == 4'h8 || bop == 4'h9 || bop == 4'ha);
   wire is_fop    = is_byte && bop != 4'h0;
   wire is_clr    = is_byte && bop == 4'h1;
   wire is_skz    = is_byte && (bop == 4'hb || bop == 4'hf);
   wire is_rot    = is_byte && (bop == 4'hc || bop == 4'hd);
   wire is_arith  = is_byte && (bop == 4'h7 || bop == 4'h2);
   wire is_blog   = is_byte && (bop == 4'h5 || bop == 4'h4 || bop == 4'h6);
   wire is_bmod   = is_bit && !iw[11];
   wire is_btst   = is_bit && iw[11];
   wire is_ret_any = is_ret || is_interrupt_return || is_return_with_literal;

   // byte ops that touch only zero
   wire z_byte = is_blog || is_clr || (is_byte && (bop == 4'h9 || bop == 4'h3 ||
                 bop == 4'ha || bop == 4'h8));

   // file operand, with status and high latch overlaid
   wire [7:0] stat_byte = {3'h0, to_reg, pd_reg, z_reg, dc_reg, c_reg};
   wire       fa_stat   = (fa == `MRID_F_STAT);
   wire       fa_pc_high_latch = (fa == `MRID_F_PC_HIGH_LATCH);
   wire [7:0] fval      = fa_stat ? stat_byte :
                          fa_pc_high_latch ? {3'h0, pc_high_latch_reg} : ex.rdata;
   wire       bit_val   = fval[iw[9:7]];

   always_comb begin
      alu_op = mrid_pkg::ALU_PASS;
      if (is_bit) begin
         alu_op = iw[10] ? mrid_pkg::ALU_BSET : mrid_pkg::ALU_BCLR;
      end else if (is_add_literal) begin
         alu_op = mrid_pkg::ALU_ADD;
      end else if (is_sub_acc_from_literal) begin
         alu_op = mrid_pkg::ALU_SUB;
      end else if (is_lit) begin
         unique case (bop)
            4'h9:    alu_op = mrid_pkg::ALU_AND;
            4'h8:    alu_op = mrid_pkg::ALU_OR;
            4'ha:    alu_op = mrid_pkg::ALU_XOR;
            default: alu_op = mrid_pkg::ALU_PASS;
         endcase
      end else if (is_byte) begin
         unique case (bop)
            4'h7:       alu_op = mrid_pkg::ALU_ADD;
            4'h2:       alu_op = mrid_pkg::ALU_SUB;
            4'h5:       alu_op = mrid_pkg::ALU_AND;
            4'h4:       alu_op = mrid_pkg::ALU_OR;
            4'h6:       alu_op = mrid_pkg::ALU_XOR;
            4'h1:       alu_op = mrid_pkg::ALU_CLR;
            4'h9:       alu_op = mrid_pkg::ALU_COM;
            4'h3, 4'hb: alu_op = mrid_pkg::ALU_DEC;
            4'ha, 4'hf: alu_op = mrid_pkg::ALU_INC;
            4'hd:       alu_op = mrid_pkg::ALU_RLC;
            4'hc:       alu_op = mrid_pkg::ALU_RRC;
            4'he:       alu_op = mrid_pkg::ALU_SWAP;
            default:    alu_op = mrid_pkg::ALU_PASS;
         endcase
      end
   end

   // four clocks per instruction cycle
   wire cyc_en = (phase_reg == 2'(`MRID_OSC_PER_CYC - 1));
   wire fire   = cyc_en && run_reg;
   wire ex_go  = fire && state_reg == mrid_pkg::ST_EXEC;

   // destinations
   wire       wr_acc  = (is_fop && !dsel) || is_lit;
   wire       wr_file = (is_fop && dsel) || is_store || is_bmod;
   wire [7:0] wdata   = is_store ? acc_reg : ex.res;
   wire       file_go = ex_go && wr_file;
   wire       st_wr   = file_go && fa_stat;

   assign ex.op    = alu_op;
   assign ex.opa   = is_lit ? lit : fval;
   assign ex.opb   = acc_reg;
   assign ex.cin   = c_reg;
   assign ex.bsel  = iw[9:7];
   assign ex.raddr = fa;
   assign ex.waddr = fa;
   assign ex.wdata = wdata;
   assign ex.we    = file_go && !fa_stat && !fa_pc_high_latch;

   // flag updates win over a plain write to the status file
   wire upd_cdc = is_arith || is_add_literal || is_sub_acc_from_literal;
   wire upd_c   = upd_cdc || is_rot;
   wire upd_z   = upd_cdc || is_llog || z_byte;
   wire c_next  = (ex_go && upd_c) ? ex.cout : st_wr ? wdata[`MRID_SB_C] : c_reg;
   wire dc_next = (ex_go && upd_cdc) ? ex.dcout : st_wr ? wdata[`MRID_SB_DC] : dc_reg;
   wire z_next  = (ex_go && upd_z) ? ex.zout : st_wr ? wdata[`MRID_SB_Z] : z_reg;

   // skips and branches
   wire take_skip   = ex_go && ((is_skz && ex.zout) ||
                      (is_btst && (iw[10] ? bit_val : !bit_val)));
   wire take_branch = ex_go && (is_call || is_jump_absolute || is_ret_any);

   wire [SPW-1:0] sp_top  = sp_reg - SPW'(1);
   wire [12:0]    pc_inc  = pc_reg + 13'h0001;
   wire [12:0]    pc_jump = {pc_high_latch_reg[4:3], iw[10:0]};
   wire [12:0]    pc_next = (is_call || is_jump_absolute) ? pc_jump :
                            is_ret_any ? stack_reg[sp_top] :
                            take_skip ? pc_reg + 13'h0002 : pc_inc;

   // register slave state
   logic        aw_rdy_reg;
   logic        w_rdy_reg;
   logic        bvalid_reg;
   logic        ar_rdy_reg;
   logic        rvalid_reg;
   logic [4:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  bresp_reg;
   logic [1:0]  rresp_reg;

   wire wr_go   = !aw_rdy_reg && !w_rdy_reg && !bvalid_reg;
   wire wr_map  = aw_addr_reg <= `MRID_A_INSN && aw_addr_reg[1:0] == 2'h0;
   wire rd_map  = s_axi_araddr <= `MRID_A_INSN && s_axi_araddr[1:0] == 2'h0;
   wire ctrl_wr = wr_go && aw_addr_reg == `MRID_A_CTRL && w_strb_reg[0];
   wire wake    = ctrl_wr && w_data_reg[`MRID_CTRL_WAKE];

   wire [31:0] rd_mux =
      (s_axi_araddr == `MRID_A_CTRL) ? {30'h0, psa_reg, run_reg} :
      (s_axi_araddr == `MRID_A_STAT) ? {22'h0, state_reg, stat_byte} :
      (s_axi_araddr == `MRID_A_PC)   ? {19'h0, pc_reg} :
      (s_axi_araddr == `MRID_A_ACC)  ? {24'h0, acc_reg} :
      (s_axi_araddr == `MRID_A_INSN) ? {18'h0, insn_reg} : 32'h0;

   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         mrid_pkg::ST_EXEC: begin
            if (ex_go && is_sleep) begin
               state_next = mrid_pkg::ST_SLEEP;
            end else if (take_branch || take_skip) begin
               state_next = mrid_pkg::ST_FLUSH;
            end
         end
         mrid_pkg::ST_FLUSH: begin
            if (fire) begin
               state_next = mrid_pkg::ST_EXEC;
            end
         end
         mrid_pkg::ST_SLEEP: begin
            if (wake) begin
               state_next = mrid_pkg::ST_EXEC;
            end
         end
         default: state_next = mrid_pkg::ST_EXEC;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         phase_reg <= 2'h0;
         state_reg <= mrid_pkg::ST_EXEC;
         pc_reg    <= `MRID_RST_PC;
         sp_reg    <= '0;
         insn_reg  <= 14'h0000;
      end else begin
         phase_reg <= phase_reg + 2'h1;
         state_reg <= state_next;
         if (ex_go) begin
            pc_reg   <= pc_next;
            insn_reg <= iw;
            if (is_call) begin
               sp_reg <= sp_reg + SPW'(1);
            end else if (is_ret_any) begin
               sp_reg <= sp_top;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (ex_go && is_call) begin
         stack_reg[sp_reg] <= pc_inc;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_reg    <= 8'h00;
         pc_high_latch_reg <= 5'h00;
         c_reg      <= 1'b0;
         dc_reg     <= 1'b0;
         z_reg      <= 1'b0;
         to_reg     <= 1'b1;
         pd_reg     <= 1'b1;
      end else begin
         c_reg  <= c_next;
         dc_reg <= dc_next;
         z_reg  <= z_next;
         if (ex_go && wr_acc) begin
            acc_reg <= ex.res;
         end
         if (file_go && fa_pc_high_latch) begin
            pc_high_latch_reg <= wdata[4:0];
         end
         if (ex_go && (is_sleep || is_wdt)) begin
            to_reg <= 1'b1;
            pd_reg <= is_wdt;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         port_out_reg        <= 8'h00;
         prescaler_clear_reg <= 1'b0;
         watchdog_clear_reg  <= 1'b0;
         standby_reg         <= 1'b0;
      end else begin
         if (file_go && fa == `MRID_F_PORT) begin
            port_out_reg <= wdata;
         end
         prescaler_clear_reg <= file_go && fa == `MRID_F_TIMER_ZERO_COUNT && psa_reg;
         watchdog_clear_reg  <= ex_go && is_wdt;
         standby_reg         <= (state_next == mrid_pkg::ST_SLEEP);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_rdy_reg  <= 1'b1;
         w_rdy_reg   <= 1'b1;
         bvalid_reg  <= 1'b0;
         bresp_reg   <= `MRID_RESP_OK;
         aw_addr_reg <= 5'h00;
         w_data_reg  <= 32'h0;
         w_strb_reg  <= 4'h0;
         run_reg     <= 1'b0;
         psa_reg     <= 1'b0;
      end else begin
         if (s_axi_awvalid && aw_rdy_reg) begin
            aw_rdy_reg  <= 1'b0;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && w_rdy_reg) begin
            w_rdy_reg  <= 1'b0;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
         end
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_map ? `MRID_RESP_OK : `MRID_RESP_ERR;
         end
         if (ctrl_wr) begin
            run_reg <= w_data_reg[`MRID_CTRL_RUN];
            psa_reg <= w_data_reg[`MRID_CTRL_PSA];
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            aw_rdy_reg <= 1'b1;
            w_rdy_reg  <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_rdy_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg  <= 32'h0;
         rresp_reg  <= `MRID_RESP_OK;
      end else if (s_axi_arvalid && ar_rdy_reg) begin
         ar_rdy_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg  <= rd_mux;
         rresp_reg  <= rd_map ? `MRID_RESP_OK : `MRID_RESP_ERR;
      end else if (rvalid_reg && s_axi_rready) begin
         rvalid_reg <= 1'b0;
         ar_rdy_reg <= 1'b1;
      end
   end

   assign s_axi_awready   = aw_rdy_reg;
   assign s_axi_wready    = w_rdy_reg;
   assign s_axi_bvalid    = bvalid_reg;
   assign s_axi_bresp     = bresp_reg;
   assign s_axi_arready   = ar_rdy_reg;
   assign s_axi_rvalid    = rvalid_reg;
   assign s_axi_rdata     = rdata_reg;
   assign s_axi_rresp     = rresp_reg;
   assign prog_addr       = pc_reg;
   assign port_out        = port_out_reg;
   assign prescaler_clear = prescaler_clear_reg;
   assign watchdog_clear  = watchdog_clear_reg;
   assign standby         = standby_reg;

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence nop_slot;
      (state_reg == mrid_pkg::ST_FLUSH) [*4] ##1 (state_reg == mrid_pkg::ST_EXEC);
   endsequence

   a_dest_acc :
      assert property (ex_go && is_fop && !dsel |=> acc_reg == $past(ex.res))
      else $error("byte result missed the accumulator");
   a_arith_flags :
      assert property (ex_go && is_arith && !(dsel && fa_stat) |=>
                       c_reg == $past(ex.cout) && dc_reg == $past(ex.dcout))
      else $error("add or subtract flags wrong");
   a_logic_keep :
      assert property (ex_go && is_blog && !fa_stat |=> $stable(c_reg) && $stable(dc_reg))
      else $error("logic op touched carry");
   a_clear_zero :
      assert property (ex_go && is_clr |=> z_reg)
      else $error("clear left zero flag low");
   a_rot_carry :
      assert property (ex_go && is_rot && !fa_stat |=> $stable(z_reg) && c_reg == $past(ex.cout))
      else $error("rotate flags wrong");
   a_skip_pc :
      assert property (take_skip && run_reg |=> pc_reg == $past(pc_reg) + 13'h0002)
      else $error("skip did not step past next word");
   a_skip_slot :
      assert property (take_skip && run_reg [*1] ##0 run_reg |=> nop_slot)
      else $error("skip missed its no-op cycle");
   a_lit_add :
      assert property (ex_go && is_add_literal |=> acc_reg == 8'($past(lit) + $past(acc_reg)))
      else $error("literal add wrong");
   a_call_pc :
      assert property (ex_go && is_call |=> pc_reg == $past(pc_jump) &&
                       stack_reg[$past(sp_reg)] == $past(pc_inc))
      else $error("call target or return address wrong");
   a_ret_slot :
      assert property (ex_go && is_ret_any |=> pc_reg == $past(stack_reg[sp_top]) ##0 nop_slot)
      else $error("return did not take two cycles");
   a_sleep_flags :
      assert property (ex_go && is_sleep |=> to_reg && !pd_reg && standby_reg)
      else $error("standby flags wrong");
   a_pin_read :
      assert property (ex_go && is_byte && bop == 4'h8 && !dsel && fa == `MRID_F_PORT |=>
                       acc_reg == $past(pins_in))
      else $error("port read did not use pins");
   a_tmr_clear :
      assert property (file_go && fa == `MRID_F_TIMER_ZERO_COUNT && psa_reg |=>
                       prescaler_clear_reg ##1 !prescaler_clear_reg)
      else $error("prescaler clear pulse wrong");
   a_cycle_len :
      assert property (cyc_en |=> !cyc_en [*3] ##1 cyc_en)
      else $error("instruction cycle not four clocks");
endmodule

// [design/mrid_exec_if.sv]
// carrier between the core, the alu and the file register store
`timescale 1ns/100ps
interface mrid_exec_if;
   mrid_pkg::mrid_alu_op_t op;
   logic [7:0]             opa;
   logic [7:0]             opb;
   logic [7:0]             res;
   logic [2:0]             bsel;
   logic                   cin;
   logic                   cout;
   logic                   dcout;
   logic                   zout;
   logic [6:0]             raddr;
   logic [6:0]             waddr;
   logic [7:0]             rdata;
   logic [7:0]             wdata;
   logic                   we;
   modport core (output op, opa, opb, bsel, cin, raddr, waddr, wdata, we,
                 input res, cout, dcout, zout, rdata);
   modport alu  (input op, opa, opb, bsel, cin, output res, cout, dcout, zout);
   modport regs (input raddr, waddr, wdata, we, output rdata);
endinterface

// [design/mrid_file.sv]
// file register store; the port address reads the pin levels
`timescale 1ns/100ps
`include "mrid_cfg.svh"
module mrid_file #(
   parameter int DEPTH = 128
) (
   input wire logic       aclk,
   input wire logic [7:0] pins_in,
   mrid_exec_if.regs      ex
);
   logic [7:0] mem [DEPTH];

   wire port_sel = (ex.raddr == `MRID_F_PORT);

   assign ex.rdata = port_sel ? pins_in : mem[ex.raddr];

   always_ff @(posedge aclk) begin
      if (ex.we) begin
         mem[ex.waddr] <= ex.wdata;
      end
   end
endmodule

// [design/mrid_pkg.sv]
// types shared by the decoder modules
package mrid_pkg;
   typedef enum logic [3:0] {
      ALU_ADD, ALU_SUB, ALU_AND, ALU_OR, ALU_XOR, ALU_CLR, ALU_PASS, ALU_COM,
      ALU_DEC, ALU_INC, ALU_RLC, ALU_RRC, ALU_SWAP, ALU_BCLR, ALU_BSET
   } mrid_alu_op_t;
   typedef enum logic [1:0] {ST_EXEC, ST_FLUSH, ST_SLEEP} mrid_state_t;
endpackage

// [tb/mrid_pmem.sv]
// program memory model that shows the word at the program counter
`timescale 1ns/100ps
module mrid_pmem (
   input  wire logic [12:0] prog_addr,
   output wire logic [13:0] prog_word
);
   logic [13:0] mem [0:8191];
   assign prog_word = mem[prog_addr];
endmodule

// [tb/tb_top.sv]
// self-checking bench running random short programs through the decoder
`timescale 1ns/100ps
`include "mrid_cfg.svh"
module tb_top;
   logic        aclk, aresetn, awv, wv, bre, arv, rre, awr, wrd, bv, arr, rv, sb, pcl, wdc;
   logic [4:0]  awa, ara;
   logic [31:0] wd, rdat;
   logic [1:0]  bres, rres;
   logic [12:0] pa;
   logic [13:0] pw;
   logic [7:0]  pins, seed, po;
   int          errors, samples_checked, n_pcl, n_wdc;
   // program tail from address 7: port, timer, watchdog, pin read, call, bit skip, sleep
   logic [13:0] prog [11] = '{14'h0086, 14'h0081, 14'h0064, 14'h0806, 14'h2011, 14'h1c06,
                              14'h01a0, 14'h0da0, 14'h02a0, 14'h0063, 14'h0008};
   initial begin
      aclk = 0;
      forever #25 aclk = ~aclk;
   end
   mrid_core DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wrd), .s_axi_bresp(bres), .s_axi_bvalid(bv), .s_axi_bready(bre),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
      .s_axi_rresp(rres), .s_axi_rvalid(rv), .s_axi_rready(rre), .prog_addr(pa),
      .prog_word(pw), .pins_in(pins), .port_out(po), .prescaler_clear(pcl),
      .watchdog_clear(wdc), .standby(sb));
   mrid_pmem PM (.prog_addr(pa), .prog_word(pw));
   // one-cycle side pulses are counted as they stand
   always @(posedge aclk) begin
      n_pcl += int'(pcl === 1'b1);
      n_wdc += int'(wdc === 1'b1);
   end
   function logic [7:0] xs();
      seed ^= seed << 3;
      seed ^= seed >> 5;
      seed ^= seed << 1;
      return seed;
   endfunction
   task ck(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task report_and_stop();
      $display("errors %0d samples_checked %0d", errors, samples_checked);
      if (errors == 0 && samples_checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task wr(input logic [4:0] a, input logic [31:0] d);
      logic ta, tw;
      ta = 0;
      tw = 0;
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bre <= 1;
      while (!(ta && tw)) begin
         @(posedge aclk);
         if (awr && !ta) begin
            ta = 1;
            awv <= 0;
         end
         if (wrd && !tw) begin
            tw = 1;
            wv <= 0;
         end
      end
      do @(posedge aclk); while (!bv);
      bre <= 0;
   endtask
   task rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      ara <= a;
      arv <= 1;
      rre <= 1;
      do @(posedge aclk); while (!arr);
      arv <= 0;
      do @(posedge aclk); while (!rv);
      d = rdat;
      r = rres;
      rre <= 0;
   endtask
   initial begin
      #(50 * 20000);
      errors++;
      report_and_stop();
   end
   initial begin
      logic [7:0]  k1, k2, k3, k4;
      logic [31:0] d;
      logic [1:0]  r;
      int          a, m, c, dc, z, f, r2, p0, w0;
      int          exq[$];
      {aresetn, awv, wv, bre, arv, rre, awa, ara, wd, pins} = '0;
      seed = 8'd55;
      repeat (4) begin
         aresetn <= 0;
         repeat (16) @(posedge aclk);
         aresetn <= 1;
         @(posedge aclk);
         k1 = xs();
         k2 = xs();
         k3 = xs();
         k4 = xs();
         pins <= k4;
         PM.mem[0] = {6'h30, k1};
         PM.mem[1] = {6'h3e, k2};
         PM.mem[2] = 14'h00a0;
         PM.mem[3] = {6'h3c, k3};
         PM.mem[4] = 14'h0620;
         PM.mem[5] = 14'h2807;
         PM.mem[6] = 14'h30ff;
         for (int i = 0; i < 11; i++) begin
            PM.mem[7 + i] = prog[i];
         end
         p0 = n_pcl;
         w0 = n_wdc;
         wr(`MRID_A_CTRL, {30'h0, k1[0], 1'b1});
         ck({30'h0, bres}, {30'h0, `MRID_RESP_OK});
         for (int i = 0; i < 400 && sb !== 1'b1; i++) @(posedge aclk);
         m = (k1 + k2) & 255;
         c = k3 >= m;
         dc = (k3 & 15) >= (m & 15);
         a = ((k3 - m) & 255) ^ m;
         // bit-set test on pin 0 skips the clear of file 0x20
         f = k4[0] ? m : 0;
         r2 = ((f << 1) | c) & 255;
         z = r2 == k4;
         dc = (r2 & 15) >= (k4 & 15);
         exq.push_back(k4);
         exq.push_back(32'h210 | (z * 4 + dc * 2 + (r2 >= k4)));
         exq.push_back(32'h11);
         rd(`MRID_A_ACC, d, r);
         ck(d, 32'(exq.pop_front()));
         ck({30'h0, r}, {30'h0, `MRID_RESP_OK});
         rd(`MRID_A_STAT, d, r);
         ck(d, 32'(exq.pop_front()));
         rd(`MRID_A_PC, d, r);
         ck(d, 32'(exq.pop_front()));
         ck({24'h0, po}, 32'(a));
         ck(32'(n_pcl - p0), 32'(k1[0]));
         ck(32'(n_wdc - w0), 32'h1);
         ck({31'h0, sb}, 32'h1);
         rd(5'h14, d, r);
         ck({30'h0, r}, {30'h0, `MRID_RESP_ERR});
      end
      report_and_stop();
   end
endmodule
